// *** logic/ir_demodulator.v ***
// Infrared receive filter that turns a long enough low pulse into a zero bit.
`timescale 1ns/1ns
`default_nettype none

module ir_demodulator (
	input wire clk_i,
	input wire rst_i,
	input wire enable_i,
	input wire rx_pin_i,
	input wire [7:0] filter_i,
	input wire [31:0] bit_len_i,
	output reg rx_o
);

	reg prev_r;
	reg counting_r;
	reg [7:0] cnt_r;
	reg [31:0] low_r;

	wire fall = prev_r && !rx_pin_i;
	wire rise = !prev_r && rx_pin_i;

	always @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= 1'b1;
			counting_r <= 1'b0;
			cnt_r <= 8'h00;
			low_r <= 32'h0;
			rx_o <= 1'b1;
		end else if (!enable_i) begin
			prev_r <= 1'b1;
			counting_r <= 1'b0;
			cnt_r <= filter_i;
			low_r <= 32'h0;
			rx_o <= 1'b1;
		end else begin
			prev_r <= rx_pin_i;
			// The reload below wins over this countdown, so back-to-back
			// zero bits keep the receiver input low without a gap.
			if (low_r != 32'h0) begin
				low_r <= low_r - 32'h1;
				rx_o <= 1'b0;
			end else begin
				rx_o <= 1'b1;
			end
			// Short glitches never reach zero, so they are filtered out.
			if (rise) begin
				counting_r <= 1'b0;
				cnt_r <= filter_i;
			end else if (fall) begin
				counting_r <= 1'b1;
				cnt_r <= filter_i;
			end else if (counting_r) begin
				if (cnt_r == 8'h00) begin
					counting_r <= 1'b0;
					low_r <= bit_len_i;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
		end
	end

endmodule // ir_demodulator

`default_nettype wire

// *** logic/ir_modulator.v ***
// Return-to-zero inverted pulse modulator for the infrared transmit path.
`timescale 1ns/1ns
`default_nettype none

module ir_modulator (
	input wire clk_i,
	input wire rst_i,
	input wire enable_i,
	input wire bit_start_i,
	input wire bit_val_i,
	input wire [31:0] pulse_len_i,
	output reg pulse_o
);

	reg [31:0] cnt_r;

	// A zero bit is a light pulse of three sixteenths of a bit; a one is dark.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 32'h0;
			pulse_o <= 1'b0;
		end else if (!enable_i) begin
			cnt_r <= 32'h0;
			pulse_o <= 1'b0;
		end else if (bit_start_i && !bit_val_i) begin
			cnt_r <= pulse_len_i - 32'h1;
			pulse_o <= 1'b1;
		end else if (cnt_r != 32'h0) begin
			cnt_r <= cnt_r - 32'h1;
		end else begin
			pulse_o <= 1'b0;
		end
	end

endmodule // ir_modulator

`default_nettype wire

// *** logic/sc_ir_map.vh ***
// Register offsets, field positions, reset values and codes of the serial block.
`ifndef SC_IR_MAP_VH
`define SC_IR_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_TX_HOLD 8'h0c
`define OFS_RX_HOLD 8'h10
`define OFS_ERR_CNT 8'h14
`define OFS_IR_FILT 8'h18
`define OFS_RATIO 8'h1c
`define OFS_CLK_DIV 8'h20

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define MODE_OP_LSB 0
`define MODE_OP_MSB 3
`define MODE_BIT_ORDER 4
`define MODE_PAR_INV 5
`define MODE_TWO_STOP 6
`define MODE_INHIBIT 7
`define MODE_SUCC_LIM 8
`define MODE_ITER_LSB 9
`define MODE_ITER_MSB 11
`define MODE_PAR_EN 12
`define MODE_W 13
`define MODE_RST 13'h0000

`define OP_SC_CHAR 4'h4
`define OP_SC_BLOCK 4'h5
`define OP_INFRARED 4'h8

// ----------------------------------------------------------------------------
// Control command bits
// ----------------------------------------------------------------------------
`define CMD_RX_EN 0
`define CMD_RX_DIS 1
`define CMD_TX_EN 2
`define CMD_TX_DIS 3
`define CMD_RST_STA 4
`define CMD_RST_ERROR_SIGNAL_BIT 5
`define CMD_RST_ITER 6

// ----------------------------------------------------------------------------
// Status bits, other reset values and fixed constants
// ----------------------------------------------------------------------------
`define ST_RX_RDY 0
`define ST_TX_RDY 1
`define ST_PAR_ERR 2
`define ST_INHIBIT 3
`define ST_ITER 4
`define ST_TX_EMPTY 5

`define RATIO_RST 11'h174
`define CLK_DIV_RST 16'h0001
`define FILT_RST 8'h00
`define ERR_CNT_MAX 8'hff
`define IR_OVERSAMPLE 16
`define IR_PULSE_NUM 3

`endif

// *** logic/sc_ir_serial.v ***
// Serial transceiver with smart-card and infrared operating modes.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "sc_ir_map.vh"

module sc_ir_serial (
	// Clock and reset
	input wire CLK_SYS_I,
	input wire RESET_I,
	// Register port
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	// Card or line pins
	input wire DATA_I,
	output reg DATA_O,
	output reg DATA_OE_O,
	output reg SCK_O,
	// Infrared transceiver pins
	input wire IR_RX_I,
	output wire IR_TX_O
);

	// ------------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------------
	localparam T_IDLE = 3'd0;
	localparam T_START = 3'd1;
	localparam T_DATA = 3'd2;
	localparam T_PAR = 3'd3;
	localparam T_STOP = 3'd4;
	localparam T_EXTRA = 3'd5;

	localparam R_IDLE = 3'd0;
	localparam R_START = 3'd1;
	localparam R_DATA = 3'd2;
	localparam R_PAR = 3'd3;
	localparam R_GUARD = 3'd4;
	localparam R_STOP = 3'd5;
	localparam R_ERROR_SIGNAL_BIT = 3'd6;

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	reg [`MODE_W-1:0] mode_r;
	reg tx_en_r;
	reg rx_en_r;
	reg [7:0] thr_r;
	reg thr_full_r;
	reg [7:0] rhr_r;
	reg rx_rdy_r;
	reg par_err_r;
	reg inhibit_flag_r;
	reg iter_flag_r;
	reg [7:0] err_cnt_r;
	reg [7:0] filter_r;
	reg [10:0] ratio_r;
	reg [15:0] cd_r;

	wire [3:0] op = mode_r[`MODE_OP_MSB:`MODE_OP_LSB];
	wire t0 = (op == `OP_SC_CHAR);
	wire sc = t0 || (op == `OP_SC_BLOCK);
	wire ir = (op == `OP_INFRARED);
	wire bit_order_select = mode_r[`MODE_BIT_ORDER];
	wire par_inv = mode_r[`MODE_PAR_INV];
	wire inhibit = mode_r[`MODE_INHIBIT];
	wire succ_lim = mode_r[`MODE_SUCC_LIM];
	wire [2:0] max_iter = mode_r[`MODE_ITER_MSB:`MODE_ITER_LSB];
	// Smart card forces parity on and ignores the parity enable field.
	wire par_on = sc || mode_r[`MODE_PAR_EN];
	// Block protocol keeps one stop bit whatever the stop field says.
	wire two_stop = mode_r[`MODE_TWO_STOP] && !(op == `OP_SC_BLOCK);

	wire wr_mode = WR_I && (ADDR_I == `OFS_MODE);
	wire wr_ctrl = WR_I && (ADDR_I == `OFS_CTRL);
	wire wr_thr = WR_I && (ADDR_I == `OFS_TX_HOLD);
	wire rd_rhr = RD_I && (ADDR_I == `OFS_RX_HOLD);
	wire rd_err = RD_I && (ADDR_I == `OFS_ERR_CNT);
	wire cmd_rst_sta = wr_ctrl && WDATA_I[`CMD_RST_STA];
	wire cmd_rst_error_signal_bit = wr_ctrl && WDATA_I[`CMD_RST_ERROR_SIGNAL_BIT];
	wire cmd_rst_iter = wr_ctrl && WDATA_I[`CMD_RST_ITER];

	// ------------------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------------------
	// A smart-card bit is the clock ratio times one card clock period.
	wire [31:0] cd_w = {16'h0, cd_r};
	wire [31:0] ratio_w = {21'h0, ratio_r};
	wire [31:0] bit_len = sc ? ((cd_w * ratio_w) << 1) :
		(cd_w * `IR_OVERSAMPLE);
	wire [31:0] half_len = {1'b0, bit_len[31:1]};
	wire [31:0] pulse_len = cd_w * `IR_PULSE_NUM;
	reg [15:0] sck_cnt_r;

	// ------------------------------------------------------------------------
	// Transmitter and receiver state
	// ------------------------------------------------------------------------
	reg [2:0] tx_st_r;
	reg [31:0] tx_cnt_r;
	reg [2:0] tx_bits_r;
	reg [7:0] tx_shift_r;
	reg [7:0] tx_hold_r;
	reg tx_par_r;
	reg tx_error_signal_bit_r;
	reg [2:0] rep_cnt_r;
	reg tx_bit_start_r;
	reg tx_line_r;

	reg [2:0] rx_st_r;
	reg [31:0] rx_cnt_r;
	reg [2:0] rx_bits_r;
	reg [7:0] rx_shift_r;
	reg rx_perr_r;
	reg [2:0] error_signal_bit_cnt_r;
	wire demod_out;
	wire rx_in = ir ? demod_out : DATA_I;

	wire tx_tick = (tx_cnt_r == 32'h0);
	wire rx_tick = (rx_cnt_r == 32'h0);
	wire tx_bit = bit_order_select ? tx_shift_r[7] : tx_shift_r[0];
	wire tx_drive = (tx_st_r == T_START) || (tx_st_r == T_DATA) ||
		(tx_st_r == T_PAR);
	wire rx_error_signal_bit = (rx_st_r == R_ERROR_SIGNAL_BIT);

	// Events from the receiver and transmitter into the flags
	reg rx_store;
	reg rx_ready_set;
	reg rx_perr_set;
	reg rx_inhibit_set;
	reg rx_iter_set;
	reg rx_err_inc;
	reg tx_iter_set;

	// ------------------------------------------------------------------------
	// Card clock
	// ------------------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RESET_I || !sc) begin
			sck_cnt_r <= 16'h0;
			SCK_O <= 1'b0;
		end else if (sck_cnt_r >= cd_r - 16'h1) begin
			sck_cnt_r <= 16'h0;
			SCK_O <= ~SCK_O;
		end else begin
			sck_cnt_r <= sck_cnt_r + 16'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			tx_st_r <= T_IDLE;
			tx_cnt_r <= 32'h0;
			tx_bits_r <= 3'd0;
			tx_shift_r <= 8'h00;
			tx_hold_r <= 8'h00;
			tx_par_r <= 1'b0;
			tx_error_signal_bit_r <= 1'b0;
			rep_cnt_r <= 3'd0;
			tx_bit_start_r <= 1'b0;
			tx_line_r <= 1'b1;
			tx_iter_set <= 1'b0;
		end else begin
			tx_bit_start_r <= 1'b0;
			tx_iter_set <= 1'b0;
			if (!tx_tick) begin
				tx_cnt_r <= tx_cnt_r - 32'h1;
			end
			case (tx_st_r)
			T_IDLE: begin
				tx_line_r <= 1'b1;
				if (tx_en_r && thr_full_r) begin
					tx_hold_r <= thr_r;
					tx_shift_r <= thr_r;
					tx_par_r <= (^thr_r) ^ par_inv;
					tx_error_signal_bit_r <= 1'b0;
					tx_cnt_r <= bit_len - 32'h1;
					tx_line_r <= 1'b0;
					tx_bit_start_r <= 1'b1;
					tx_st_r <= T_START;
				end
			end
			T_START: begin
				if (tx_tick) begin
					tx_cnt_r <= bit_len - 32'h1;
					tx_bits_r <= 3'd0;
					tx_line_r <= tx_bit;
					tx_bit_start_r <= 1'b1;
					tx_st_r <= T_DATA;
				end
			end
			T_DATA: begin
				if (tx_tick) begin
					tx_cnt_r <= bit_len - 32'h1;
					tx_bit_start_r <= 1'b1;
					tx_bits_r <= tx_bits_r + 3'd1;
					if (tx_bits_r == 3'd7) begin
						tx_line_r <= par_on ? tx_par_r : 1'b1;
						tx_bits_r <= 3'd0;
						tx_st_r <= par_on ? T_PAR : T_STOP;
					end else begin
						tx_shift_r <= bit_order_select ? {tx_shift_r[6:0], 1'b0} :
							{1'b0, tx_shift_r[7:1]};
						tx_line_r <= bit_order_select ? tx_shift_r[6] : tx_shift_r[1];
					end
				end
			end
			T_PAR: begin
				if (tx_tick) begin
					tx_cnt_r <= bit_len - 32'h1;
					tx_bit_start_r <= 1'b1;
					tx_line_r <= 1'b1;
					tx_bits_r <= 3'd0;
					tx_st_r <= T_STOP;
				end
			end
			T_STOP: begin
				// In card modes the line is released here; the card may pull it low.
				if (t0 && tx_bits_r == 3'd0 && tx_cnt_r == half_len &&
					!DATA_I) begin
					tx_error_signal_bit_r <= 1'b1;
				end
				if (tx_tick) begin
					tx_cnt_r <= bit_len - 32'h1;
					if ((t0 || two_stop) && tx_bits_r == 3'd0) begin
						tx_bits_r <= 3'd1;
					end else if (tx_error_signal_bit_r) begin
						tx_st_r <= T_EXTRA;
					end else begin
						rep_cnt_r <= 3'd0;
						tx_st_r <= T_IDLE;
					end
				end
			end
			T_EXTRA: begin
				// The error signal lengthens the character by one bit.
				if (tx_tick) begin
					if (max_iter != 3'd0 && rep_cnt_r != max_iter) begin
						rep_cnt_r <= rep_cnt_r + 3'd1;
						tx_shift_r <= tx_hold_r;
						tx_error_signal_bit_r <= 1'b0;
						tx_cnt_r <= bit_len - 32'h1;
						tx_line_r <= 1'b0;
						tx_bit_start_r <= 1'b1;
						tx_st_r <= T_START;
					end else begin
						tx_iter_set <= (max_iter != 3'd0);
						rep_cnt_r <= 3'd0;
						tx_st_r <= T_IDLE;
					end
				end
			end
			default: begin
				tx_st_r <= T_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			rx_st_r <= R_IDLE;
			rx_cnt_r <= 32'h0;
			rx_bits_r <= 3'd0;
			rx_shift_r <= 8'h00;
			rx_perr_r <= 1'b0;
			error_signal_bit_cnt_r <= 3'd0;
			rx_store <= 1'b0;
			rx_ready_set <= 1'b0;
			rx_perr_set <= 1'b0;
			rx_inhibit_set <= 1'b0;
			rx_iter_set <= 1'b0;
			rx_err_inc <= 1'b0;
		end else begin
			rx_store <= 1'b0;
			rx_ready_set <= 1'b0;
			rx_perr_set <= 1'b0;
			rx_inhibit_set <= 1'b0;
			rx_iter_set <= 1'b0;
			rx_err_inc <= 1'b0;
			if (!rx_tick) begin
				rx_cnt_r <= rx_cnt_r - 32'h1;
			end
			case (rx_st_r)
			R_IDLE: begin
				if (rx_en_r && !rx_in) begin
					rx_cnt_r <= half_len;
					rx_st_r <= R_START;
				end
			end
			R_START: begin
				if (rx_tick) begin
					rx_cnt_r <= bit_len - 32'h1;
					rx_bits_r <= 3'd0;
					rx_st_r <= rx_in ? R_IDLE : R_DATA;
				end
			end
			R_DATA: begin
				if (rx_tick) begin
					rx_cnt_r <= bit_len - 32'h1;
					rx_shift_r <= bit_order_select ? {rx_shift_r[6:0], rx_in} :
						{rx_in, rx_shift_r[7:1]};
					rx_bits_r <= rx_bits_r + 3'd1;
					if (rx_bits_r == 3'd7) begin
						rx_st_r <= par_on ? R_PAR : R_STOP;
					end
				end
			end
			R_PAR: begin
				if (rx_tick) begin
					rx_perr_r <= (^rx_shift_r) ^ rx_in ^ par_inv;
					// The guard time begins half a bit after this sample.
					rx_cnt_r <= t0 ? half_len : bit_len - 32'h1;
					rx_st_r <= t0 ? R_GUARD : R_STOP;
				end
			end
			R_GUARD: begin
				if (rx_tick) begin
					rx_st_r <= R_IDLE;
					if (!rx_perr_r) begin
						rx_store <= 1'b1;
						rx_ready_set <= 1'b1;
						error_signal_bit_cnt_r <= 3'd0;
					end else if (inhibit) begin
						rx_err_inc <= 1'b1;
						rx_inhibit_set <= 1'b1;
						rx_store <= 1'b1;
					end else if (succ_lim && error_signal_bit_cnt_r == max_iter) begin
						rx_store <= 1'b1;
						rx_ready_set <= 1'b1;
						rx_iter_set <= 1'b1;
						error_signal_bit_cnt_r <= 3'd0;
					end else begin
						rx_err_inc <= 1'b1;
						rx_perr_set <= 1'b1;
						error_signal_bit_cnt_r <= error_signal_bit_cnt_r + 3'd1;
						rx_cnt_r <= bit_len - 32'h1;
						rx_st_r <= R_ERROR_SIGNAL_BIT;
					end
				end
			end
			R_ERROR_SIGNAL_BIT: begin
				if (rx_tick) begin
					rx_st_r <= R_IDLE;
				end
			end
			R_STOP: begin
				if (rx_tick) begin
					rx_st_r <= R_IDLE;
					rx_store <= 1'b1;
					rx_ready_set <= 1'b1;
					rx_perr_set <= par_on && rx_perr_r;
					rx_err_inc <= sc && par_on && rx_perr_r;
				end
			end
			default: begin
				rx_st_r <= R_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------
	// Outside smart-card mode the pin is an ordinary push-pull output.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			DATA_O <= 1'b1;
			DATA_OE_O <= 1'b0;
		end else begin
			DATA_O <= rx_error_signal_bit ? 1'b0 : tx_line_r;
			DATA_OE_O <= rx_error_signal_bit || (sc ? tx_drive : 1'b1);
		end
	end

	ir_modulator u_mod (
		.clk_i(CLK_SYS_I),
		.rst_i(RESET_I),
		.enable_i(ir),
		.bit_start_i(tx_bit_start_r),
		.bit_val_i(tx_line_r),
		.pulse_len_i(pulse_len),
		.pulse_o(IR_TX_O)
	);

	ir_demodulator u_demod (
		.clk_i(CLK_SYS_I),
		.rst_i(RESET_I),
		.enable_i(ir),
		.rx_pin_i(IR_RX_I),
		.filter_i(filter_r),
		.bit_len_i(bit_len),
		.rx_o(demod_out)
	);

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	// Every flag gives a set in the same cycle as its clear priority.
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			mode_r <= `MODE_RST;
			tx_en_r <= 1'b0;
			rx_en_r <= 1'b0;
			thr_r <= 8'h00;
			thr_full_r <= 1'b0;
			rhr_r <= 8'h00;
			rx_rdy_r <= 1'b0;
			par_err_r <= 1'b0;
			inhibit_flag_r <= 1'b0;
			iter_flag_r <= 1'b0;
			err_cnt_r <= 8'h00;
			filter_r <= `FILT_RST;
			ratio_r <= `RATIO_RST;
			cd_r <= `CLK_DIV_RST;
			RDATA_O <= 32'h0;
		end else begin
			if (wr_mode) begin
				mode_r <= WDATA_I[`MODE_W-1:0];
			end
			if (wr_ctrl) begin
				if (WDATA_I[`CMD_RX_DIS]) begin
					rx_en_r <= 1'b0;
				end else if (WDATA_I[`CMD_RX_EN]) begin
					rx_en_r <= 1'b1;
				end
				if (WDATA_I[`CMD_TX_DIS]) begin
					tx_en_r <= 1'b0;
				end else if (WDATA_I[`CMD_TX_EN]) begin
					tx_en_r <= 1'b1;
				end
			end
			if (WR_I && ADDR_I == `OFS_IR_FILT) begin
				filter_r <= WDATA_I[7:0];
			end
			if (WR_I && ADDR_I == `OFS_RATIO) begin
				ratio_r <= WDATA_I[10:0];
			end
			if (WR_I && ADDR_I == `OFS_CLK_DIV) begin
				cd_r <= WDATA_I[15:0];
			end
			if (wr_thr) begin
				thr_r <= WDATA_I[7:0];
				thr_full_r <= 1'b1;
			end else if (tx_st_r == T_IDLE && tx_en_r && thr_full_r) begin
				thr_full_r <= 1'b0;
			end
			if (rx_store) begin
				rhr_r <= rx_shift_r;
			end
			if (rx_ready_set) begin
				rx_rdy_r <= 1'b1;
			end else if (rd_rhr) begin
				rx_rdy_r <= 1'b0;
			end
			if (rx_perr_set) begin
				par_err_r <= 1'b1;
			end else if (cmd_rst_sta) begin
				par_err_r <= 1'b0;
			end
			if (rx_inhibit_set) begin
				inhibit_flag_r <= 1'b1;
			end else if (cmd_rst_error_signal_bit) begin
				inhibit_flag_r <= 1'b0;
			end
			if (tx_iter_set || rx_iter_set) begin
				iter_flag_r <= 1'b1;
			end else if (cmd_rst_iter) begin
				iter_flag_r <= 1'b0;
			end
			if (rx_err_inc) begin
				if (rd_err) begin
					err_cnt_r <= 8'h01;
				end else if (err_cnt_r != `ERR_CNT_MAX) begin
					err_cnt_r <= err_cnt_r + 8'h01;
				end
			end else if (rd_err) begin
				err_cnt_r <= 8'h00;
			end
			if (RD_I) begin
				case (ADDR_I)
				`OFS_MODE: RDATA_O <= {19'h0, mode_r};
				`OFS_STATUS: RDATA_O <= {26'h0,
					(tx_st_r == T_IDLE) && !thr_full_r, iter_flag_r,
					inhibit_flag_r, par_err_r, !thr_full_r, rx_rdy_r};
				`OFS_RX_HOLD: RDATA_O <= {24'h0, rhr_r};
				`OFS_ERR_CNT: RDATA_O <= {24'h0, err_cnt_r};
				`OFS_IR_FILT: RDATA_O <= {24'h0, filter_r};
				`OFS_RATIO: RDATA_O <= {21'h0, ratio_r};
				`OFS_CLK_DIV: RDATA_O <= {16'h0, cd_r};
				default: RDATA_O <= 32'h0;
				endcase
			end else begin
				RDATA_O <= 32'h0;
			end
		end
	end

endmodule // sc_ir_serial

`default_nettype wire

// *** verification/card_model.sv ***
// Behavioural smart card on the far side of the shared data line.
`timescale 1ns/1ns
`default_nettype none
module card_model #(
	parameter int BT = 8
) (
	input wire logic clk_i,
	input wire logic io_i,
	output logic low_o
);
	// ------------------------------------------------------------
	// Receive from the device, error signal on demand
	// ------------------------------------------------------------
	logic [9:0] rx_f;
	int n_rx = 0;
	int error_signal_bit_left = 0;
	bit sending = 0;
	initial low_o = 1'b0;
	// Samples land one step after the edge so the line has settled.
	always begin : watch
		@(negedge io_i iff !sending);
		repeat (BT / 2) @(posedge clk_i);
		for (int i = 0; i < 10; i++) begin
			#1 rx_f[i] = io_i;
			repeat (i < 9 ? BT : BT / 2) @(posedge clk_i);
		end
		if (error_signal_bit_left > 0) begin
			error_signal_bit_left--;
			low_o <= 1'b1;
			repeat (BT) @(posedge clk_i);
			low_o <= 1'b0;
		end
		n_rx++;
	end
	task automatic send(input logic [7:0] d, input bit bad, output bit nk);
		logic [9:0] f;
		f = {(^d) ^ bad, d, 1'b0};
		sending = 1;
		for (int i = 0; i < 10; i++) begin
			low_o <= ~f[i];
			repeat (BT) @(posedge clk_i);
		end
		low_o <= 1'b0;
		repeat (BT / 2) @(posedge clk_i);
		#1 nk = !io_i;
		repeat (2 * BT) @(posedge clk_i);
		sending = 0;
	endtask
endmodule // card_model
`default_nettype wire

// *** verification/sc_ir_serial_assertions.sv ***
// Port checker for the serial transceiver, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
`include "sc_ir_map.vh"
module sc_ir_serial_assertions (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [31:0] RDATA_O,
	// Line and infrared pins
	input wire logic DATA_I,
	input wire logic DATA_O,
	input wire logic DATA_OE_O,
	input wire logic SCK_O,
	input wire logic IR_RX_I,
	input wire logic IR_TX_O
);
	// ------------------------------------------------------------
	// Shadow of the settings written by software
	// ------------------------------------------------------------
	logic [12:0] mode_r;
	logic [7:0] filt_r;
	logic [15:0] cd_r;
	logic [3:0] stab_r;
	wire sc = mode_r[3:0] == `OP_SC_CHAR || mode_r[3:0] == `OP_SC_BLOCK;
	// Pin checks other than the pulse length check wait eight cycles after a mode or divider write, since a
	// pulse or clock phase in flight may finish under the old setting.
	wire settled = stab_r > 4'h7;
	always @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			mode_r <= `MODE_RST;
			filt_r <= `FILT_RST;
			cd_r <= `CLK_DIV_RST;
			stab_r <= 4'h0;
		end else begin
			if (WR_I && ADDR_I == `OFS_MODE)
				mode_r <= WDATA_I[12:0];
			if (WR_I && ADDR_I == `OFS_IR_FILT)
				filt_r <= WDATA_I[7:0];
			if (WR_I && ADDR_I == `OFS_CLK_DIV)
				cd_r <= WDATA_I[15:0];
			if (WR_I && (ADDR_I == `OFS_MODE || ADDR_I == `OFS_CLK_DIV))
				stab_r <= 4'h0;
			else if (!settled)
				stab_r <= stab_r + 4'h1;
		end
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data not zero outside a read");
	AST_MODE_RB: assert property (RD_I && ADDR_I == `OFS_MODE |=>
		RDATA_O == {19'h0, mode_r}) else $error("mode readback wrong");
	AST_FILT_RB: assert property (RD_I && ADDR_I == `OFS_IR_FILT |=>
		RDATA_O == {24'h0, filt_r}) else $error("filter readback wrong");
	AST_CNT_W: assert property (RD_I && ADDR_I == `OFS_ERR_CNT |=>
		RDATA_O[31:8] == 24'h0) else $error("error count too wide");
	AST_CNT_CLR: assert property ((RD_I && ADDR_I == `OFS_ERR_CNT) [*2]
		|=> RDATA_O < 32'h2) else $error("error count not cleared by read");
	AST_IR_ONLY: assert property (settled && mode_r[3:0] != `OP_INFRARED
		|-> !IR_TX_O) else $error("infrared pulse outside infrared mode");
	AST_IR_PULSE: assert property ($rose(IR_TX_O) && cd_r == 16'h1
		|-> IR_TX_O [*3] ##1 !IR_TX_O) else $error("pulse length wrong");
	AST_SCK_OFF: assert property (settled && !sc |-> !SCK_O)
		else $error("card clock running outside card modes");
	AST_SCK_RUN: assert property (settled && sc && cd_r == 16'h1
		|-> SCK_O != $past(SCK_O)) else $error("card clock not toggling");
	AST_OE_ASYNC: assert property (settled && !sc |-> DATA_OE_O)
		else $error("line released outside card modes");
	COV_IR: cover property ($rose(IR_TX_O));
	COV_ERR_SIG: cover property (sc && DATA_OE_O && !DATA_O);
	COV_CNT: cover property (RD_I && ADDR_I == `OFS_ERR_CNT);
endmodule // sc_ir_serial_assertions
bind sc_ir_serial sc_ir_serial_assertions chk (.CLK_SYS_I, .RESET_I,
	.ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .DATA_I, .DATA_O,
	.DATA_OE_O, .SCK_O, .IR_RX_I, .IR_TX_O);
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench of the transceiver in card and infrared modes.
`timescale 1ns/1ns
`default_nettype none
`include "sc_ir_map.vh"
module tb;
	// ------------------------------------------------------------
	// Design, card and shared line with pull-up
	// ------------------------------------------------------------
	logic clk, rst, wr, rd, ir_rx, dout, doe, sck, ir_tx, low, prev;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	wire io = (doe ? dout : 1'b1) & ~low;
	int n_fail = 0;
	int comparisons = 0;
	int k;
	bit nk;
	logic [7:0] ra [7] = '{8'h00, 8'h18, 8'h1c, 8'h20, 8'h14, 8'h04, 8'h24};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h174, 32'h1, 32'h0, 32'h0, 32'h0};
	sc_ir_serial uut (.CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.DATA_I(io), .DATA_O(dout), .DATA_OE_O(doe), .SCK_O(sck),
		.IR_RX_I(ir_rx), .IR_TX_O(ir_tx));
	card_model #(.BT(8)) card (.clk_i(clk), .io_i(io), .low_o(low));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so take them then.
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 2000 && card.n_rx < n; i++)
			@(posedge clk);
		if (card.n_rx < n) begin
			n_fail++;
			final_report();
		end
	endtask
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		ir_rx = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1 chk("pins in reset", {doe, dout, sck, ir_tx}, 4'h4);
		@(posedge clk);
		#1 chk("line enable", doe, 1'b1);
		for (k = 0; k < 7; k++) begin
			rd_reg(ra[k]);
			chk("register", q, rv[k]);
		end
		wr_reg(`OFS_RATIO, 32'h4);
		wr_reg(`OFS_IR_FILT, 32'hffffffa5);
		rd_reg(`OFS_IR_FILT);
		chk("filter", q, 32'ha5);
		card.error_signal_bit_left = 2;
		wr_reg(`OFS_MODE, 32'h204);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_TX_EN);
		wr_reg(`OFS_TX_HOLD, 32'hc3);
		wait_rx(2);
		chk("card byte", card.rx_f[8:1], 8'hc3);
		chk("card parity", card.rx_f[9], ^card.rx_f[8:1]);
		repeat (300) @(posedge clk);
		chk("sendings", card.n_rx, 2);
		rd_reg(`OFS_STATUS);
		chk("limit flag", q[`ST_ITER], 1'b1);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_RST_ITER);
		rd_reg(`OFS_STATUS);
		chk("limit flag", q[`ST_ITER], 1'b0);
		wr_reg(`OFS_CTRL, (32'h1 << `CMD_TX_DIS) | 32'h1);
		card.send(8'h5a, 1'b0, nk);
		chk("error signal", nk, 1'b0);
		rd_reg(`OFS_RX_HOLD);
		chk("rx hold", q, 32'h5a);
		card.send(8'h33, 1'b1, nk);
		chk("error signal", nk, 1'b1);
		rd_reg(`OFS_STATUS);
		chk("status", {q[`ST_PAR_ERR], q[`ST_RX_RDY]}, 2'h2);
		rd_reg(`OFS_RX_HOLD);
		chk("rx hold", q, 32'h5a);
		@(posedge clk);
		addr <= `OFS_ERR_CNT;
		rd <= 1'b1;
		@(posedge clk);
		#1 chk("error count", rdata, 32'h1);
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("error count", rdata, 32'h0);
		wr_reg(`OFS_MODE, 32'h84);
		card.send(8'h66, 1'b1, nk);
		chk("error signal", nk, 1'b0);
		rd_reg(`OFS_STATUS);
		chk("status", {q[`ST_INHIBIT], q[`ST_RX_RDY]}, 2'h2);
		rd_reg(`OFS_RX_HOLD);
		chk("rx hold", q, 32'h66);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_RST_ERROR_SIGNAL_BIT);
		rd_reg(`OFS_STATUS);
		chk("inhibit flag", q[`ST_INHIBIT], 1'b0);
		wr_reg(`OFS_MODE, 32'h304);
		card.send(8'h21, 1'b0, nk);
		card.send(8'h42, 1'b1, nk);
		chk("error signal", nk, 1'b1);
		card.send(8'h42, 1'b1, nk);
		chk("error signal", nk, 1'b0);
		rd_reg(`OFS_STATUS);
		chk("status", {q[`ST_ITER], q[`ST_RX_RDY]}, 2'h3);
		rd_reg(`OFS_RX_HOLD);
		chk("rx hold", q, 32'h42);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_RST_STA);
		wr_reg(`OFS_MODE, 32'h5);
		card.send(8'h77, 1'b1, nk);
		chk("error signal", nk, 1'b0);
		rd_reg(`OFS_STATUS);
		chk("parity flag", q[`ST_PAR_ERR], 1'b1);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_RX_DIS);
		wr_reg(`OFS_MODE, 32'h8);
		wr_reg(`OFS_CTRL, 32'h1 << `CMD_TX_EN);
		wr_reg(`OFS_TX_HOLD, 32'h0e);
		k = 0;
		prev = 1'b0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1;
			if (ir_tx && !prev)
				k++;
			prev = ir_tx;
		end
		chk("ir pulses", k, 6);
		wr_reg(`OFS_IR_FILT, 32'h1);
		wr_reg(`OFS_CTRL, (32'h1 << `CMD_TX_DIS) | 32'h1);
		q = 32'h2a4;
		for (int i = 0; i < 10; i++) begin
			ir_rx <= q[i];
			repeat (3) @(posedge clk);
			ir_rx <= 1'b1;
			repeat (13) @(posedge clk);
		end
		rd_reg(`OFS_RX_HOLD);
		chk("ir rx hold", q, 32'h52);
		final_report();
	end
endmodule // tb
`default_nettype wire
